// ===== hdl/dsp_instruction_decoder.sv
// Contract
// RULE1: Top nibble picks add/sub/load with shift
// RULE2: Five bits pick shifted upper store
// RULE3: 0110_00xx give upper/unsigned add/sub
// RULE4: 0111_10xx give xor, and, or
// RULE5: Conditional subtract and clear-load forms, single cycle
// RULE6: Magnitude and clear are fixed words
// RULE7: 01010000 stores lower word, one cycle
// RULE8: Low byte immediate for two loads
// RULE9: Bit 8 selects auxiliary register
// RULE10: Modify pointer touches no operand
// RULE11: Page load from memory or LSB
// RULE12: Branches take two words, two cycles
// RULE13: Conditional branches each own opcode byte
// RULE14: Call via accumulator: one word, two cycles
// RULE15: Return one word; call two words
// RULE16: Leading 100 gives 13-bit multiply immediate
// RULE17: Multiply memory and load multiplicand decoded
// RULE18: Combined multiplicand loads decode single cycle
// RULE19: Stack moves take two cycles
// RULE20: Port in/out with 3-bit port field
// RULE21: Table read/write take three cycles
// RULE22: Data move copies to next address
// RULE23: Direct address is page plus seven bits
// RULE24: Indirect address from selected auxiliary register
// RULE25: Unknown words act as single-cycle no-op
`timescale 1ns/1ps
`default_nettype none
`include "dsid_defs.svh"
module dsp_instruction_decoder
	import dsid_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             instrValid,
	input  wire logic [15:0]      instrWord,
	input  wire logic             pagePointer,
	input  wire logic             auxSelectPointer,
	input  wire logic [7:0]       auxReg0Low,
	input  wire logic [7:0]       auxReg1Low,
	output var  dsid_decode_type  decodeOut,
	output var  logic             secondWordPending
);
	// Word tracking state; ST_SECOND means the next taken word is a target
	dsid_state_type  state_reg;
	// Decode of a first word waiting for its second
	// Kept whole so the address inputs of the first word's cycle are reported
	dsid_decode_type held_reg;
	// Combinational decode of the current word
	dsid_decode_type firstDecode;

	// Classify a word and fill every field it carries
	// Tests run from the wide opcode groups through the fixed words to the byte-wide opcodes, so the
	// order matters: a fixed word must never be caught by a prefix test above
	// it. Anything left over ends as a one-cycle no-op.
	function automatic dsid_decode_type decode_word(input logic [15:0] w, input logic page,
		input logic aux_select_pointer, input logic [7:0] ar0, input logic [7:0] ar1);
		dsid_decode_type d;
		// Most opcodes read a data operand; immediate and fixed forms clear this
		logic memOp;
		// Defaults: one word, one cycle, raw fields copied out
		d = '0;
		memOp = 1'b1;
		d.op = OP_NOP;
		d.valid = 1'b1;
		d.words = 2'h1;
		d.cycles = `DSID_CYC_ONE;
		d.indirect = w[`DSID_MODE_BIT];
		d.auxSelect = w[`DSID_AUX_SEL_BIT];
		d.portSelectField = w[`DSID_PORT_HI:`DSID_PORT_LO];
		// RULE1 shifted accumulator group
		if (w[15:12] == 4'h0) begin
			// Shift code sits right below the opcode nibble
			d.op = OP_ADD_SH;
			d.shift = w[`DSID_SHIFT_HI:`DSID_SHIFT_LO];
		end else if (w[15:12] == 4'h1) begin
			d.op = OP_SUB_SH;
			d.shift = w[`DSID_SHIFT_HI:`DSID_SHIFT_LO];
		end else if (w[15:12] == 4'h2) begin
			d.op = OP_LOAD_ACC_SHIFTED;
			d.shift = w[`DSID_SHIFT_HI:`DSID_SHIFT_LO];
		// RULE16 multiply by 13-bit immediate
		end else if (w[15:13] == 3'h4) begin
			// Leading 100 covers an eighth of all codes
			d.op = OP_MULTIPLY_IMMEDIATE;
			d.immediate = w[12:0];
			memOp = 1'b0;
		// RULE2 shifted upper store, 3-bit shift
		end else if (w[15:11] == 5'h0B) begin
			d.op = OP_STORE_UPPER_SHIFTED;
			// Three-bit shift widened to the common field
			d.shift = {1'b0, w[10:8]};
		// RULE20 port transfers, two cycles
		end else if (w[15:12] == 4'h4) begin
			// Bit 11 tells output from input
			d.op = w[11] ? OP_PORT_OUT : OP_PORT_IN;
			d.cycles = `DSID_CYC_TWO;
		// RULE9 auxiliary register load/store
		end else if (w[15:9] == 7'h1C) begin
			// Register select stays in the raw copy of bit 8
			d.op = OP_LOAD_AUX_REG;
		end else if (w[15:9] == 7'h18) begin
			d.op = OP_STORE_AUX_REG;
		// RULE8 auxiliary immediate in low byte
		end else if (w[15:9] == 7'h38) begin
			d.op = OP_LOAD_AUX_IMMEDIATE;
			d.immediate = {5'h00, w[7:0]};
			memOp = 1'b0;
		end else if (w == `DSID_W_MAGNITUDE) begin
			// RULE6 fixed magnitude word
			d.op = OP_MAGNITUDE_OF_ACC;
			memOp = 1'b0;
		end else if (w == `DSID_W_CLEAR_ACC) begin
			// RULE6 fixed clear word
			d.op = OP_CLEAR_ACC;
			memOp = 1'b0;
		end else if (w == `DSID_W_ACC_PROD) begin
			// Product added to accumulator, no operand
			d.op = OP_ACCUMULATE_PRODUCT;
			memOp = 1'b0;
		end else if (w == `DSID_W_POP || w == `DSID_W_PUSH) begin
			// RULE19 stack moves two cycles
			d.op = (w == `DSID_W_POP) ? OP_POP : OP_PUSH;
			d.cycles = `DSID_CYC_TWO;
			memOp = 1'b0;
		end else if (w == `DSID_W_CALL_ACC) begin
			// RULE14 call via accumulator, one word
			d.op = OP_CALL_VIA_ACC;
			// Target comes from the accumulator, not a second word
			d.cycles = `DSID_CYC_TWO;
			memOp = 1'b0;
		end else if (w == `DSID_W_RETURN) begin
			// RULE15 return, one word two cycles
			d.op = OP_RETURN_OP;
			d.cycles = `DSID_CYC_TWO;
			memOp = 1'b0;
		end else if (w[15:8] == 8'h6E && w[7:1] == 7'h00) begin
			// RULE11 immediate page from the LSB
			d.op = OP_LOAD_PAGE_IMMEDIATE;
			// Only the LSB carries the new page
			d.immediate = {12'h000, w[0]};
			memOp = 1'b0;
		end else if (w[15:12] == 4'hF && w[7:0] == 8'h00) begin
			// RULE12 branch family, two words
			d.words = 2'h2;
			d.cycles = `DSID_CYC_TWO;
			d.hasTarget = 1'b1;
			// Target arrives with the next taken word
			memOp = 1'b0;
			// RULE13 each condition by its byte
			case (w[11:8])
				4'h9:    d.op = OP_BRANCH;
				4'h4:    d.op = OP_BRANCH_AUX_NONZERO;
				4'hD:    d.op = OP_BRANCH_NONNEGATIVE;
				4'hC:    d.op = OP_BRANCH_POSITIVE;
				4'hB:    d.op = OP_BRANCH_NONPOSITIVE;
				4'hA:    d.op = OP_BRANCH_NEGATIVE;
				4'hE:    d.op = OP_BRANCH_NONZERO;
				4'h5:    d.op = OP_BRANCH_OVERFLOW;
				4'hF:    d.op = OP_BRANCH_ZERO;
				4'h6:    d.op = OP_BRANCH_POLL_LOW;
				// RULE15 immediate call carries its target
				4'h8:    d.op = OP_CALL;
				// Unused condition codes fall to the no-op below
				default: d.op = OP_NOP;
			endcase
		end else begin
			// Byte-wide opcodes with memory operand, except 7E and 68
			case (w[15:8])
				// RULE3 upper and unsigned add/sub
				8'h60:   d.op = OP_SUM_UPPER_WORD;
				8'h61:   d.op = OP_SUM_UNSIGNED_EXTEND;
				8'h62:   d.op = OP_SUBTRACT_UPPER_WORD;
				8'h63:   d.op = OP_SUBTRACT_UNSIGNED_EXTEND;
				// RULE5 conditional subtract and clear-loads
				8'h64:   d.op = OP_CONDITIONAL_SUBTRACT;
				8'h65:   d.op = OP_CLEAR_THEN_LOAD_UPPER;
				8'h66:   d.op = OP_CLEAR_THEN_LOAD_LOWER;
				// RULE4 logical group
				8'h78:   d.op = OP_XOR;
				8'h79:   d.op = OP_AND;
				8'h7A:   d.op = OP_OR;
				// RULE7 lower word store
				8'h50:   d.op = OP_STORE_LOWER_WORD;
				// RULE10 pointer update only
				8'h68:   d.op = OP_MODIFY_AUX_POINTER;
				// RULE11 page from memory
				8'h6F:   d.op = OP_LOAD_PAGE_SELECT;
				// RULE17 multiply and multiplicand load
				8'h6D:   d.op = OP_MULTIPLY_MEMORY;
				8'h6A:   d.op = OP_LOAD_MULTIPLICAND;
				// RULE18 combined loads
				8'h6C:   d.op = OP_LOAD_MCAND_ACCUMULATE;
				8'h6B:   d.op = OP_LOAD_MCAND_ACC_MOVE;
				// RULE22 data move upward
				8'h69:   d.op = OP_DATA_SHIFT_UP;
				// RULE8 immediate load; operand taken below
				8'h7E:   d.op = OP_LOAD_ACC_IMMEDIATE;
				// RULE21 table moves; cycles set below
				8'h67:   d.op = OP_TABLE_READ;
				8'h7D:   d.op = OP_TABLE_WRITE;
				// Status and control words not listed here
				default: d.op = OP_NOP;
			endcase
			// RULE8 accumulator immediate in low byte
			if (d.op == OP_LOAD_ACC_IMMEDIATE) begin
				d.immediate = {5'h00, w[7:0]};
				memOp = 1'b0;
			end
			// RULE21 table moves three cycles
			if (d.op == OP_TABLE_READ || d.op == OP_TABLE_WRITE) begin
				d.cycles = `DSID_CYC_THREE;
			end
			// RULE10 no operand access
			if (d.op == OP_MODIFY_AUX_POINTER) begin
				memOp = 1'b0;
			end
		end
		// RULE25 unknown word is a plain no-op
		if (d.op == OP_NOP) begin
			// Wipe every field so no stale operand reaches the core
			d = '0;
			d.op = OP_NOP;
			d.valid = 1'b1;
			d.words = 2'h1;
			d.cycles = `DSID_CYC_ONE;
			memOp = 1'b0;
		end
		// Report operand use so the core knows whether to touch data memory
		d.usesMemory = memOp;
		// Mode bit only means something when there is an operand
		if (!memOp) begin
			d.indirect = 1'b0;
		end
		// RULE24 indirect address from selected register
		if (memOp && d.indirect) begin
			d.dataAddr = aux_select_pointer ? ar1 : ar0;
		// RULE23 direct: page bit over seven bits
		end else if (memOp) begin
			d.dataAddr = {page, w[6:0]};
		end
		// Non-memory forms keep a zero address
		return d;
	endfunction

	// Decode the current word
	// Pure function of the inputs; pointer and registers are sampled with it
	always_comb begin
		firstDecode = decode_word(instrWord, pagePointer, auxSelectPointer, auxReg0Low, auxReg1Low);
	end

	// Word tracking: a two-word op waits for its target word
	// A gap between the two words is allowed; the state simply waits
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			// Reset drops any half-taken branch
			state_reg <= ST_FIRST;
			held_reg <= '0;
		end else if (instrValid) begin
			case (state_reg)
				ST_FIRST: begin
					if (firstDecode.words == 2'h2) begin
						state_reg <= ST_SECOND;
						// Remember the first word whole
						held_reg <= firstDecode;
					end
				end
				ST_SECOND: begin
					// Whatever arrives now is the target word
					state_reg <= ST_FIRST;
				end
				// Unreachable state: start over
				default: state_reg <= ST_FIRST;
			endcase
		end
	end

	// Registered result; two-word ops emerge with their target
	always_ff @(posedge mclk or negedge resetn) begin
		// decodeOut is all zero except in the cycle after a decode
		if (!resetn) begin
			decodeOut <= '0;
			secondWordPending <= 1'b0;
		end else begin
			// Default: a result stands for one cycle only
			decodeOut <= '0;
			secondWordPending <= 1'b0;
			if (instrValid && state_reg == ST_SECOND) begin
				// RULE12 second word: four zeros then target
				// Top nibble of the target word is not checked
				decodeOut <= held_reg;
				decodeOut.target <= instrWord[11:0];
			end else if (instrValid && firstDecode.words == 2'h2) begin
				// First of two words: nothing to report yet
				secondWordPending <= 1'b1;
			end else if (instrValid) begin
				// One-word op reported at once
				decodeOut <= firstDecode;
			end else begin
				// Idle cycle: keep showing a pending target
				secondWordPending <= (state_reg == ST_SECOND);
			end
		end
	end
endmodule
`default_nettype wire

// ===== hdl/dsid_defs.svh
`ifndef DSID_DEFS_SVH
`define DSID_DEFS_SVH
// Instruction field positions
`define DSID_SHIFT_HI      11
`define DSID_SHIFT_LO      8
`define DSID_MODE_BIT      7
`define DSID_PORT_HI       10
`define DSID_PORT_LO       8
`define DSID_AUX_SEL_BIT   8
// Fixed whole-word codes
`define DSID_W_MAGNITUDE   16'h7F88
`define DSID_W_CLEAR_ACC   16'h7F89
`define DSID_W_ACC_PROD    16'h7F8F
`define DSID_W_POP         16'h7F9D
`define DSID_W_PUSH        16'h7F9C
`define DSID_W_CALL_ACC    16'h7F8C
`define DSID_W_RETURN      16'h7F8D
// Cycle counts
`define DSID_CYC_ONE       2'h1
`define DSID_CYC_TWO       2'h2
`define DSID_CYC_THREE     2'h3
`endif

// ===== hdl/dsid_pkg.sv
`default_nettype none
package dsid_pkg;
	// Decoded operation
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD_SH, OP_SUB_SH, OP_LOAD_ACC_SHIFTED, OP_STORE_UPPER_SHIFTED,
		OP_SUM_UPPER_WORD, OP_SUM_UNSIGNED_EXTEND, OP_SUBTRACT_UPPER_WORD, OP_SUBTRACT_UNSIGNED_EXTEND,
		OP_XOR, OP_AND, OP_OR, OP_CONDITIONAL_SUBTRACT, OP_CLEAR_THEN_LOAD_UPPER,
		OP_CLEAR_THEN_LOAD_LOWER, OP_MAGNITUDE_OF_ACC, OP_CLEAR_ACC, OP_STORE_LOWER_WORD,
		OP_LOAD_AUX_IMMEDIATE, OP_LOAD_ACC_IMMEDIATE, OP_LOAD_AUX_REG, OP_STORE_AUX_REG,
		OP_MODIFY_AUX_POINTER, OP_LOAD_PAGE_SELECT, OP_LOAD_PAGE_IMMEDIATE,
		OP_BRANCH, OP_BRANCH_AUX_NONZERO, OP_BRANCH_NONNEGATIVE, OP_BRANCH_POSITIVE,
		OP_BRANCH_NONPOSITIVE, OP_BRANCH_NEGATIVE, OP_BRANCH_NONZERO, OP_BRANCH_OVERFLOW,
		OP_BRANCH_ZERO, OP_BRANCH_POLL_LOW, OP_CALL_VIA_ACC, OP_CALL, OP_RETURN_OP,
		OP_MULTIPLY_IMMEDIATE, OP_MULTIPLY_MEMORY, OP_LOAD_MULTIPLICAND,
		OP_LOAD_MCAND_ACCUMULATE, OP_LOAD_MCAND_ACC_MOVE, OP_ACCUMULATE_PRODUCT,
		OP_POP, OP_PUSH, OP_PORT_IN, OP_PORT_OUT, OP_TABLE_READ, OP_TABLE_WRITE,
		OP_DATA_SHIFT_UP
	} dsid_op_type;

	// Decoder result carried as one word
	typedef struct packed {
		dsid_op_type op;
		logic        valid;
		logic [1:0]  words;
		logic [1:0]  cycles;
		logic        indirect;
		logic [7:0]  dataAddr;
		logic        usesMemory;
		logic [3:0]  shift;
		logic [12:0] immediate;
		logic        auxSelect;
		logic [2:0]  portSelectField;
		logic        hasTarget;
		logic [11:0] target;
	} dsid_decode_type;

	// Second-word tracking
	typedef enum logic {ST_FIRST, ST_SECOND} dsid_state_type;
endpackage
`default_nettype wire

// ===== verification/dsid_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsid_fetch_model (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        fetchReq,
	input  wire logic [15:0] fetchWord,
	output var  logic        instrValid,
	output var  logic [15:0] instrWord
);
	// Program memory returns a requested word one cycle later
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			instrValid <= 1'b0;
			instrWord  <= 16'h0000;
		end else begin
			instrValid <= fetchReq;
			// Idle bus shows the inverse, so a stale word never looks valid
			instrWord  <= fetchReq ? fetchWord : ~instrWord;
		end
	end
endmodule
`default_nettype wire

// ===== verification/dsid_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dsid_decoder_properties
	import dsid_pkg::*;
(
	input wire logic            mclk,
	input wire logic            resetn,
	input wire logic            instrValid,
	input wire logic [15:0]     instrWord,
	input wire logic            pagePointer,
	input wire logic            auxSelectPointer,
	input wire logic [7:0]      auxReg0Low,
	input wire logic [7:0]      auxReg1Low,
	input wire dsid_decode_type decodeOut,
	input wire logic            secondWordPending
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// A taken word that is not a branch target
	logic firstWord;
	assign firstWord = instrValid && !secondWordPending;
	sequence s_branch_first;
		firstWord && instrWord[7:0] == 8'h00 && instrWord[15:8] inside {8'hF9, 8'hF4, 8'hFD, 8'hFC, 8'hF6, 8'hFB};
	endsequence
	sequence s_target_taken;
		secondWordPending && instrValid;
	endsequence
	property p_branch_waits;
		s_branch_first |=> secondWordPending && !decodeOut.valid;
	endproperty
	a_branch_waits: assert property (p_branch_waits) else $error("branch decoded early");
	property p_target_pair;
		s_target_taken |=> decodeOut.valid && decodeOut.words == 2'h2 && decodeOut.cycles == 2'h2
			&& decodeOut.target == $past(instrWord[11:0]) && !secondWordPending;
	endproperty
	a_target_pair: assert property (p_target_pair) else $error("bad two-word decode");
	property p_one_word;
		firstWord && !(instrWord[15:12] == 4'hF && instrWord[7:0] == 8'h00) |=> decodeOut.valid && decodeOut.words == 2'h1;
	endproperty
	a_one_word: assert property (p_one_word) else $error("one-word decode missing");
	property p_mult_imm;
		firstWord && instrWord[15:13] == 3'h4 |=> decodeOut.op == OP_MULTIPLY_IMMEDIATE
			&& decodeOut.immediate == $past(instrWord[12:0]) && decodeOut.cycles == 2'h1;
	endproperty
	a_mult_imm: assert property (p_mult_imm) else $error("multiply immediate");
	property p_direct;
		firstWord && instrWord[15:12] == 4'h0 && !instrWord[7] |=> decodeOut.op == OP_ADD_SH
			&& decodeOut.shift == $past(instrWord[11:8]) && decodeOut.dataAddr == {$past(pagePointer), $past(instrWord[6:0])};
	endproperty
	a_direct: assert property (p_direct) else $error("direct address");
	property p_indirect;
		firstWord && instrWord[15:8] == 8'h60 && instrWord[7] |=> decodeOut.indirect
			&& decodeOut.dataAddr == ($past(auxSelectPointer) ? $past(auxReg1Low) : $past(auxReg0Low));
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect address");
	property p_table;
		firstWord && instrWord[15:8] inside {8'h67, 8'h7D} |=> decodeOut.cycles == 2'h3;
	endproperty
	a_table: assert property (p_table) else $error("table cycles");
	property p_port;
		firstWord && instrWord[15:12] == 4'h4 |=> decodeOut.cycles == 2'h2
			&& decodeOut.portSelectField == $past(instrWord[10:8]);
	endproperty
	a_port: assert property (p_port) else $error("port decode");
	property p_aux_imm;
		firstWord && instrWord[15:9] == 7'h38 |=> decodeOut.op == OP_LOAD_AUX_IMMEDIATE
			&& decodeOut.auxSelect == $past(instrWord[8]) && decodeOut.immediate[7:0] == $past(instrWord[7:0]);
	endproperty
	a_aux_imm: assert property (p_aux_imm) else $error("aux immediate");
endmodule
bind dsp_instruction_decoder dsid_decoder_properties u_props (.mclk(mclk), .resetn(resetn), .instrValid(instrValid),
	.instrWord(instrWord), .pagePointer(pagePointer), .auxSelectPointer(auxSelectPointer), .auxReg0Low(auxReg0Low),
	.auxReg1Low(auxReg1Low), .decodeOut(decodeOut), .secondWordPending(secondWordPending));
`default_nettype wire

// ===== verification/tb_dsp_instruction_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_dsp_instruction_decoder
	import dsid_pkg::*;
;
	typedef struct packed {logic [15:0] w; dsid_op_type op; logic [1:0] c;} dsid_case_type;
	logic            mclk = 1'b0;
	logic            resetn = 1'b0;
	logic            fetchReq = 1'b0;
	logic [15:0]     fetchWord = 16'h0000;
	logic            instrValid;
	logic [15:0]     instrWord;
	logic            pagePointer = 1'b0;
	logic            auxSelectPointer = 1'b0;
	logic [7:0]      auxReg0Low = 8'h00;
	logic [7:0]      auxReg1Low = 8'h00;
	dsid_decode_type decodeOut;
	logic            secondWordPending;
	int              n_fail = 0;
	int              cmp_count = 0;
	always #20 mclk = ~mclk;
	dsid_fetch_model u_mem (.mclk(mclk), .resetn(resetn), .fetchReq(fetchReq), .fetchWord(fetchWord),
		.instrValid(instrValid), .instrWord(instrWord));
	dsp_instruction_decoder u_dut (.mclk(mclk), .resetn(resetn), .instrValid(instrValid), .instrWord(instrWord),
		.pagePointer(pagePointer), .auxSelectPointer(auxSelectPointer), .auxReg0Low(auxReg0Low),
		.auxReg1Low(auxReg1Low), .decodeOut(decodeOut), .secondWordPending(secondWordPending));
	// Request one word; the last word of a group waits until its decode has landed
	task automatic issue(input logic [15:0] w, input logic last);
		@(posedge mclk);
		fetchReq  <= 1'b1;
		fetchWord <= w;
		if (last) begin
			@(posedge mclk);
			fetchReq <= 1'b0;
			@(posedge mclk);
			@(negedge mclk);
		end
	endtask
	task automatic t_fields();
		@(posedge mclk);
		pagePointer      <= 1'b1;
		auxReg0Low       <= 8'h33;
		auxReg1Low       <= 8'h5C;
		auxSelectPointer <= 1'b1;
		issue(16'h0A25, 1'b1);
		`CHK(decodeOut.shift, 4'hA)
		`CHK(decodeOut.dataAddr, 8'hA5)
		`CHK(decodeOut.op, OP_ADD_SH)
		`CHK(decodeOut.indirect, 1'b0)
		issue(16'h6081, 1'b1);
		`CHK(decodeOut.dataAddr, 8'h5C)
		`CHK(decodeOut.op, OP_SUM_UPPER_WORD)
		`CHK(decodeOut.indirect, 1'b1)
		`CHK(decodeOut.usesMemory, 1'b1)
		@(posedge mclk);
		auxSelectPointer <= 1'b0;
		issue(16'h60FF, 1'b1);
		`CHK(decodeOut.dataAddr, 8'h33)
		$display("t_fields done");
	endtask
	task automatic t_imm();
		issue(16'h9ABC, 1'b1);
		`CHK(decodeOut.immediate, 13'h1ABC)
		issue(16'h715A, 1'b1);
		`CHK(decodeOut.immediate, 13'h005A)
		`CHK(decodeOut.usesMemory, 1'b0)
		issue(16'h3980, 1'b1);
		`CHK(decodeOut.auxSelect, 1'b1)
		issue(16'h4D85, 1'b1);
		`CHK(decodeOut.portSelectField, 3'h5)
		issue(16'h5D12, 1'b1);
		`CHK(decodeOut.shift, 4'h5)
		issue(16'h6E01, 1'b1);
		`CHK(decodeOut.op, OP_LOAD_PAGE_IMMEDIATE)
		`CHK(decodeOut.immediate, 13'h0001)
		issue(16'h6880, 1'b1);
		`CHK(decodeOut.usesMemory, 1'b0)
		`CHK(decodeOut.indirect, 1'b0)
		$display("t_imm done");
	endtask
	// Every listed one-word code with its cycle count
	task automatic t_table();
		dsid_case_type tc [41] = '{'{16'h1000,OP_SUB_SH,2'h1}, '{16'h2000,OP_LOAD_ACC_SHIFTED,2'h1},
			'{16'h6100,OP_SUM_UNSIGNED_EXTEND,2'h1}, '{16'h6200,OP_SUBTRACT_UPPER_WORD,2'h1},
			'{16'h6300,OP_SUBTRACT_UNSIGNED_EXTEND,2'h1}, '{16'h7800,OP_XOR,2'h1}, '{16'h7900,OP_AND,2'h1},
			'{16'h7A00,OP_OR,2'h1}, '{16'h6400,OP_CONDITIONAL_SUBTRACT,2'h1},
			'{16'h6500,OP_CLEAR_THEN_LOAD_UPPER,2'h1}, '{16'h6600,OP_CLEAR_THEN_LOAD_LOWER,2'h1},
			'{16'h5000,OP_STORE_LOWER_WORD,2'h1}, '{16'h7E00,OP_LOAD_ACC_IMMEDIATE,2'h1},
			'{16'h3000,OP_STORE_AUX_REG,2'h1}, '{16'h6800,OP_MODIFY_AUX_POINTER,2'h1},
			'{16'h6F00,OP_LOAD_PAGE_SELECT,2'h1}, '{16'h7F8C,OP_CALL_VIA_ACC,2'h2},
			'{16'h7F8D,OP_RETURN_OP,2'h2}, '{16'h6D00,OP_MULTIPLY_MEMORY,2'h1},
			'{16'h6A00,OP_LOAD_MULTIPLICAND,2'h1}, '{16'h6C00,OP_LOAD_MCAND_ACCUMULATE,2'h1},
			'{16'h6B00,OP_LOAD_MCAND_ACC_MOVE,2'h1}, '{16'h7F9D,OP_POP,2'h2}, '{16'h7F9C,OP_PUSH,2'h2},
			'{16'h4000,OP_PORT_IN,2'h2}, '{16'h6700,OP_TABLE_READ,2'h3}, '{16'h7D00,OP_TABLE_WRITE,2'h3},
			'{16'h6900,OP_DATA_SHIFT_UP,2'h1}, '{16'hFF01,OP_NOP,2'h1}, '{16'h0000,OP_ADD_SH,2'h1},
			'{16'h6000,OP_SUM_UPPER_WORD,2'h1}, '{16'h5800,OP_STORE_UPPER_SHIFTED,2'h1},
			'{16'h3800,OP_LOAD_AUX_REG,2'h1}, '{16'h4800,OP_PORT_OUT,2'h2},
			'{16'h8000,OP_MULTIPLY_IMMEDIATE,2'h1}, '{16'h7000,OP_LOAD_AUX_IMMEDIATE,2'h1},
			'{16'h6E00,OP_LOAD_PAGE_IMMEDIATE,2'h1}, '{16'h7F88,OP_MAGNITUDE_OF_ACC,2'h1},
			'{16'h7F89,OP_CLEAR_ACC,2'h1}, '{16'h7F8F,OP_ACCUMULATE_PRODUCT,2'h1}, '{16'hF000,OP_NOP,2'h1}};
		for (int i = 0; i < 41; i++) begin
			issue(tc[i].w, 1'b1);
			`CHK(decodeOut.op, tc[i].op)
			`CHK(decodeOut.cycles, tc[i].c)
			`CHK(decodeOut.words, 2'h1)
			`CHK(decodeOut.valid, 1'b1)
		end
		// Back to back words with no gap
		issue(16'h7F88, 1'b0);
		issue(16'h7F89, 1'b1);
		`CHK(decodeOut.op, OP_CLEAR_ACC)
		$display("t_table done");
	endtask
	task automatic t_branch();
		logic [7:0]  code [11] = '{8'hF9, 8'hF4, 8'hFD, 8'hFC, 8'hF6, 8'hFB, 8'hFA, 8'hFE, 8'hF5, 8'hFF, 8'hF8};
		dsid_op_type bop [11] = '{OP_BRANCH, OP_BRANCH_AUX_NONZERO, OP_BRANCH_NONNEGATIVE, OP_BRANCH_POSITIVE,
			OP_BRANCH_POLL_LOW, OP_BRANCH_NONPOSITIVE, OP_BRANCH_NEGATIVE, OP_BRANCH_NONZERO,
			OP_BRANCH_OVERFLOW, OP_BRANCH_ZERO, OP_CALL};
		for (int i = 0; i < 11; i++) begin
			// Odd entries leave a gap between the two words
			issue({code[i], 8'h00}, 1'(i % 2));
			if (i % 2) begin
				`CHK(secondWordPending, 1'b1)
				`CHK(decodeOut.valid, 1'b0)
			end
			issue({4'h0, 8'hA5, 4'(i)}, 1'b1);
			`CHK(decodeOut.op, bop[i])
			`CHK(decodeOut.words, 2'h2)
			`CHK(decodeOut.cycles, 2'h2)
			`CHK(decodeOut.target, {8'hA5, 4'(i)})
			`CHK(decodeOut.hasTarget, 1'b1)
			`CHK(secondWordPending, 1'b0)
		end
		$display("t_branch done");
	endtask
	// Reset in mid-run drops a waiting branch; the next word is a fresh op
	task automatic t_reset();
		issue(16'hF800, 1'b1);
		`CHK(secondWordPending, 1'b1)
		@(posedge mclk);
		resetn <= 1'b0;
		@(negedge mclk);
		`CHK(secondWordPending, 1'b0)
		`CHK(decodeOut.valid, 1'b0)
		@(posedge mclk);
		resetn <= 1'b1;
		issue(16'h7E42, 1'b1);
		`CHK(decodeOut.op, OP_LOAD_ACC_IMMEDIATE)
		`CHK(decodeOut.immediate, 13'h0042)
		$display("t_reset done");
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog: the tests need about 225 cycles
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		t_fields();
		t_imm();
		t_table();
		t_branch();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire
